// file: shared/fns_pkg.sv
// Constants, register offsets and the configuration carrier of the synthesizer
// divider configuration block. Assumes byte-wide registers on a 15-bit address.
package fns_pkg;
  // ----------------------------------------------------------------
  // Register map sections and single registers
  // ----------------------------------------------------------------
  localparam logic [14:0] STD_CFG_ADDR = 15'h0000;
  localparam logic [14:0] STD_LAST_ADDR = 15'h000D;
  localparam logic [14:0] SYN_FIRST_ADDR = 15'h0010;
  localparam logic [14:0] SYN_LAST_ADDR = 15'h007C;
  localparam logic [14:0] MIX_FIRST_ADDR = 15'h0100;
  localparam logic [14:0] MIX_LAST_ADDR = 15'h0119;
  localparam logic [14:0] PAGE_ADDR = 15'h0117;
  localparam logic [14:0] INT_LO_ADDR = 15'h0010;
  localparam logic [14:0] INT_HI_ADDR = 15'h0011;
  localparam logic [14:0] PRESEL_ADDR = 15'h0012;
  localparam logic [14:0] F1_B0_ADDR = 15'h0014;
  localparam logic [14:0] F1_B1_ADDR = 15'h0015;
  localparam logic [14:0] F1_B2_ADDR = 15'h0016;
  localparam logic [14:0] F1_B3_ADDR = 15'h0017;
  localparam logic [14:0] F2_HI_ADDR = 15'h0018;
  localparam logic [14:0] M2_LO_ADDR = 15'h0019;
  localparam logic [14:0] M2_HI_ADDR = 15'h001A;
  localparam logic [14:0] PUMP_ADDR = 15'h001E;
  localparam logic [14:0] RWORD_ADDR = 15'h001F;
  localparam logic [14:0] REFCTL_ADDR = 15'h0022;
  localparam logic [14:0] BIAS_ADDR = 15'h0027;
  localparam logic [14:0] SDPD_ADDR = 15'h002B;
  localparam int SYN_DEPTH = 109;
  localparam int MIX_DEPTH = 26;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PAGE_BIT = 6;
  localparam int SDO_EN_BIT = 4;
  localparam int PRESEL_BIT = 5;
  localparam int DOUBLER_BIT = 5;
  localparam int HALF_BIT = 4;
  localparam int SDPD_BIT = 0;
  localparam int PUMP_LSB = 4;
  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_INT_LO = 8'h64;
  localparam logic [7:0] RST_AUXILIARY_DENOMINATOR_LO = 8'h02;
  localparam logic [7:0] RST_PUMP = 8'hB0;
  localparam logic [7:0] RST_RWORD = 8'h01;
  localparam logic [7:0] RST_BIAS = 8'h01;
  localparam logic [5:0] RDIV_MAX = 6'h20;
  localparam logic [12:0] PUMP_STEP_UA = 13'h015E;
  localparam logic [15:0] INT_MIN_45 = 16'h0017;
  localparam logic [15:0] INT_MAX_45 = 16'h01FF;
  localparam logic [15:0] INT_MIN_89 = 16'h004B;
  localparam logic [15:0] INT_MAX_89 = 16'h03FF;
  // Double-buffered divider and reference configuration.
  typedef struct packed {
    logic [15:0] whole;
    logic [24:0] primary_numerator;
    logic [13:0] auxiliary_numerator;
    logic [13:0] auxiliary_denominator;
    logic [4:0] rword;
    logic doubler;
    logic half;
    logic [3:0] pump;
  } fns_cfg_type;
endpackage

// file: hw/fns_divider_config.sv
// Register file, reference divider, feedback divider and modulator of a
// fractional-N synthesizer. Assumes refTick and vcoTick are one-cycle enables
// synchronous to clk, one per reference and per oscillator edge.
//
// Behaviour
// - Writing 0x4C to 0x117 selects the mixer section for readback.
// - Writing 0x0C to the page register selects the synthesizer section.
// - Bit 5 of 0x022 doubles the reference before the dividers.
// - Reference path: doubler, 5-bit counter 1..32, optional divide by two.
// - Counter ratio from 0x01F bits 4:0; 1 bypasses, 0 means 32.
// - Comparison rate is ref times (1+D) over R times (1+T), never above the ref rate.
// - Feedback divides oscillator by N; oscillator equals comparison rate times N.
// - 0x012 bit 5 picks 4/5 (23..511) or 8/9 (75..1023) prescaler.
// - N is whole plus (primary_numerator plus auxiliary_numerator over auxiliary_denominator) over 2^25.
// - Auxiliary numerator 14 bits 0..16383; auxiliary modulus 2..16383.
// - Primary numerator 0..33554431; whole part is 16 bits.
// - Both numerators zero is integer mode; 0x02B bit 0 powers modulators down.
// - Primary and auxiliary moduli together give 39-bit fractional resolution.
// - Pump current is (code plus one) times 350 uA from 0x01E bits 7:4.
// - Default pump register code is 11, giving 4.2 mA once applied; the active code resets to 0 (350 uA).
// - Buffered fields apply only on writing 0x010, which also starts calibration.
// - Standard and mixer readback need page bit 1; synthesizer needs 0.
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
module fns_divider_config (
  input wire logic clk, // 200 MHz clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic ce, // Clock enable; low freezes all state.
  input wire logic [14:0] regAddr, // Register address.
  input wire logic [7:0] regWdata, // Register write data.
  input wire logic regWr, // Write strobe.
  input wire logic regRd, // Read strobe.
  output logic [7:0] regRdata, // Read data, the cycle after the strobe.
  input wire logic refTick, // One pulse per reference edge.
  input wire logic vcoTick, // One pulse per oscillator edge.
  output logic pfdTick, // Reference-side comparison pulse.
  output logic fbTick, // Feedback-side comparison pulse.
  output logic calStart, // Apply and calibration start pulse.
  output logic [3:0] pumpCode, // Active pump current code.
  output logic [12:0] pumpMicroamp, // Pump current in microamps.
  output logic intMode, // Both active numerators are zero.
  output logic modPowerDown, // Modulators powered down.
  output logic [1:0] prescalerBias, // Prescaler bias field.
  output logic prescalerEightNine, // 8/9 prescaler selected.
  output logic divideInRange, // Whole part legal for the prescaler.
  output logic sdoEnable, // Serial data out pin enabled.
  output logic readPageSynth // Readback serves the synthesizer section.
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] syn_q [fns_pkg::SYN_DEPTH];
  logic [7:0] mix_q [fns_pkg::MIX_DEPTH];
  logic [7:0] stdCfg_q;
  logic [7:0] regRdata_q;
  logic calStart_q;
  fns_pkg::fns_cfg_type act_q;
  logic [6:0] refAcc_q;
  logic [16:0] nCnt_q;
  logic [14:0] aux_q;
  logic [24:0] pri_q;
  // Reset image of the synthesizer section.
  function automatic logic [7:0] synReset(input int idx);
    logic [14:0] a;
    a = fns_pkg::SYN_FIRST_ADDR + 15'(idx);
    unique case (a)
      fns_pkg::INT_LO_ADDR: synReset = fns_pkg::RST_INT_LO;
      fns_pkg::M2_LO_ADDR: synReset = fns_pkg::RST_AUXILIARY_DENOMINATOR_LO;
      fns_pkg::PUMP_ADDR: synReset = fns_pkg::RST_PUMP;
      fns_pkg::RWORD_ADDR: synReset = fns_pkg::RST_RWORD;
      fns_pkg::BIAS_ADDR: synReset = fns_pkg::RST_BIAS;
      default: synReset = 8'h00;
    endcase
  endfunction
  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire logic inStd = regAddr <= fns_pkg::STD_LAST_ADDR;
  wire logic inSyn = regAddr >= fns_pkg::SYN_FIRST_ADDR && regAddr <= fns_pkg::SYN_LAST_ADDR;
  wire logic inMix = regAddr >= fns_pkg::MIX_FIRST_ADDR && regAddr <= fns_pkg::MIX_LAST_ADDR;
  wire logic [6:0] synIdx = 7'(regAddr - fns_pkg::SYN_FIRST_ADDR);
  wire logic [4:0] mixIdx = 5'(regAddr - fns_pkg::MIX_FIRST_ADDR);
  wire logic wrIntLo = ce && regWr && regAddr == fns_pkg::INT_LO_ADDR;
  wire logic pageBit = mix_q[5'(fns_pkg::PAGE_ADDR - fns_pkg::MIX_FIRST_ADDR)][fns_pkg::PAGE_BIT];
  // Readback gating by the page bit; unmapped addresses read zero.
  wire logic [7:0] rdStd = (regAddr == fns_pkg::STD_CFG_ADDR) ? stdCfg_q : 8'h00;
  wire logic [7:0] rdMux = (inSyn && !pageBit) ? syn_q[synIdx] :
    (inMix && pageBit) ? mix_q[mixIdx] :
    (inStd && pageBit) ? rdStd : 8'h00;
  // Fields as they stand in the written (shadow) registers.
  function automatic logic [7:0] sb(input logic [14:0] a);
    sb = syn_q[7'(a - fns_pkg::SYN_FIRST_ADDR)];
  endfunction
  // Named bytes of the written registers. A function result cannot be
  // sliced, so each byte gets a wire before its fields are picked out.
  wire logic [7:0] intHiByte = sb(fns_pkg::INT_HI_ADDR);
  wire logic [7:0] intLoByte = sb(fns_pkg::INT_LO_ADDR);
  wire logic [7:0] f1B0Byte = sb(fns_pkg::F1_B0_ADDR);
  wire logic [7:0] f1B1Byte = sb(fns_pkg::F1_B1_ADDR);
  wire logic [7:0] f1B2Byte = sb(fns_pkg::F1_B2_ADDR);
  wire logic [7:0] f1B3Byte = sb(fns_pkg::F1_B3_ADDR);
  wire logic [7:0] f2HiByte = sb(fns_pkg::F2_HI_ADDR);
  wire logic [7:0] m2LoByte = sb(fns_pkg::M2_LO_ADDR);
  wire logic [7:0] m2HiByte = sb(fns_pkg::M2_HI_ADDR);
  wire logic [7:0] rwordByte = sb(fns_pkg::RWORD_ADDR);
  wire logic [7:0] refCtlByte = sb(fns_pkg::REFCTL_ADDR);
  wire logic [7:0] pumpByte = sb(fns_pkg::PUMP_ADDR);
  wire logic [7:0] preselByte = sb(fns_pkg::PRESEL_ADDR);
  wire logic [7:0] biasByte = sb(fns_pkg::BIAS_ADDR);
  wire logic [7:0] sdpdByte = sb(fns_pkg::SDPD_ADDR);
  fns_pkg::fns_cfg_type shadow;
  always_comb
  begin
    shadow.whole = {intHiByte, intLoByte};
    shadow.primary_numerator = {f1B3Byte[0], f1B2Byte, f1B1Byte, f1B0Byte};
    shadow.auxiliary_numerator = {f2HiByte[6:0], f1B3Byte[7:1]};
    shadow.auxiliary_denominator = {m2HiByte[5:0], m2LoByte};
    shadow.rword = rwordByte[4:0];
    shadow.doubler = refCtlByte[fns_pkg::DOUBLER_BIT];
    shadow.half = refCtlByte[fns_pkg::HALF_BIT];
    shadow.pump = pumpByte[fns_pkg::PUMP_LSB +: 4];
  end
  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Every synthesizer-section write lands in the shadow; descending order by the host keeps the
  // buffered fields ready before the low whole byte applies them.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < fns_pkg::SYN_DEPTH; i++)
        syn_q[i] <= synReset(i);
      for (int i = 0; i < fns_pkg::MIX_DEPTH; i++)
        mix_q[i] <= 8'h00;
      stdCfg_q <= 8'h00;
    end
    else if (ce && regWr)
    begin
      if (inSyn)
        syn_q[synIdx] <= regWdata;
      if (inMix)
        mix_q[mixIdx] <= regWdata;
      if (regAddr == fns_pkg::STD_CFG_ADDR)
        stdCfg_q <= regWdata;
    end
  end
  // Read data stand for exactly the cycle after the strobe.
  always_ff @(posedge clk)
  begin
    if (srst)
      regRdata_q <= 8'h00;
    else if (ce)
      regRdata_q <= regRd ? rdMux : 8'h00;
  end
  // The apply pulse follows the low whole byte write by one cycle, so the
  // byte itself is already in the shadow when it is copied.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      calStart_q <= 1'b0;
      act_q <= '0;
    end
    else if (ce)
    begin
      calStart_q <= wrIntLo;
      if (calStart_q)
        act_q <= shadow;
    end
  end
  // ----------------------------------------------------------------
  // Reference path
  // ----------------------------------------------------------------
  // Rate accumulator: each reference edge adds 1 or 2 (doubler) and a pulse
  // leaves per R*(1+T) units. At most one pulse per reference edge, so a
  // doubled reference with a total ratio of one is limited to the input rate.
  wire logic [5:0] rBase = (act_q.rword == 5'h00) ? fns_pkg::RDIV_MAX : {1'b0, act_q.rword};
  wire logic [6:0] refDiv = act_q.half ? {rBase, 1'b0} : {1'b0, rBase};
  wire logic [6:0] refStep = act_q.doubler ? 7'h02 : 7'h01;
  wire logic [6:0] refSum = refAcc_q + refStep;
  wire logic refHit = refTick && refSum >= refDiv;
  wire logic [6:0] refRem = refSum - refDiv;
  wire logic [6:0] refAccD = !refTick ? refAcc_q :
    !refHit ? refSum : (refRem >= refDiv) ? refDiv - 7'h01 : refRem;
  always_ff @(posedge clk)
  begin
    if (srst || (ce && calStart_q))
      refAcc_q <= 7'h00;
    else if (ce)
      refAcc_q <= refAccD;
  end
  // ----------------------------------------------------------------
  // Modulator and feedback divider
  // ----------------------------------------------------------------
  // First-order cascade: the auxiliary remainder carries into the primary
  // accumulator, whose overflow past 2^25 lengthens the next feedback cycle.
  wire logic pdLive = sdpdByte[fns_pkg::SDPD_BIT];
  wire logic fbEnd = vcoTick && nCnt_q <= 17'h00001;
  wire logic [14:0] auxSum = aux_q + {1'b0, act_q.auxiliary_numerator};
  wire logic auxCarry = auxSum >= {1'b0, act_q.auxiliary_denominator};
  wire logic [14:0] auxD = auxCarry ? auxSum - {1'b0, act_q.auxiliary_denominator} : auxSum;
  wire logic [25:0] priSum = {1'b0, pri_q} + {1'b0, act_q.primary_numerator} + {25'h0000_000, auxCarry};
  wire logic priCarry = priSum[25] && !pdLive;
  wire logic [16:0] nRatio = {1'b0, act_q.whole} + {16'h0000, priCarry};
  always_ff @(posedge clk)
  begin
    if (srst || (ce && calStart_q))
    begin
      aux_q <= 15'h0000;
      pri_q <= 25'h000_0000;
      nCnt_q <= 17'h0_0000;
    end
    else if (ce && vcoTick)
    begin
      nCnt_q <= fbEnd ? nRatio : nCnt_q - 17'h00001;
      if (fbEnd && !pdLive)
      begin
        aux_q <= auxD;
        pri_q <= priSum[24:0];
      end
    end
  end
  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  wire logic [4:0] pumpSteps = {1'b0, act_q.pump} + 5'h01;
  assign regRdata = regRdata_q;
  assign calStart = calStart_q;
  assign pfdTick = ce && refHit;
  assign fbTick = ce && fbEnd;
  assign pumpCode = act_q.pump;
  assign pumpMicroamp = 13'(pumpSteps * fns_pkg::PUMP_STEP_UA);
  assign intMode = act_q.primary_numerator == 25'h000_0000 && act_q.auxiliary_numerator == 14'h0000;
  // Prescaler controls and modulator power-down act at once; divider, reference and pump fields wait for the apply.
  assign modPowerDown = pdLive;
  assign prescalerBias = biasByte[1:0];
  assign prescalerEightNine = preselByte[fns_pkg::PRESEL_BIT];
  assign divideInRange = prescalerEightNine ?
    (act_q.whole >= fns_pkg::INT_MIN_89 && act_q.whole <= fns_pkg::INT_MAX_89) :
    (act_q.whole >= fns_pkg::INT_MIN_45 && act_q.whole <= fns_pkg::INT_MAX_45);
  assign sdoEnable = stdCfg_q[fns_pkg::SDO_EN_BIT];
  assign readPageSynth = !pageBit;
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Apply path: the low whole byte write, then the pulse, then the copy.
  sequence applyWrite;
    ce && regWr && regAddr == fns_pkg::INT_LO_ADDR;
  endsequence
  sequence applyPulse;
    calStart ##1 (!$past(ce) || act_q == $past(shadow));
  endsequence
  apply_start_a: assert property (@(posedge clk) disable iff (srst)
    applyWrite |=> applyPulse) else $error("low whole byte write did not apply config");
  hold_cfg_a: assert property (@(posedge clk) disable iff (srst)
    !$past(calStart) |-> $stable(act_q)) else $error("active config changed without apply");
  cal_only_a: assert property (@(posedge clk) disable iff (srst)
    ce && !(regWr && regAddr == fns_pkg::INT_LO_ADDR) |=> !calStart) else $error("apply pulse without write");
  // Readback stands one cycle and respects the page bit.
  read_synth_a: assert property (@(posedge clk) disable iff (srst)
    ce && regRd && inSyn && pageBit |=> regRdata == 8'h00) else $error("synth read while mixer page");
  read_mix_a: assert property (@(posedge clk) disable iff (srst)
    ce && regRd && inMix && pageBit |=> regRdata == $past(mix_q[mixIdx])) else $error("mixer read wrong");
  read_pulse_a: assert property (@(posedge clk) disable iff (srst)
    ce && !regRd |=> regRdata == 8'h00) else $error("read data outside its cycle");
  read_std_a: assert property (@(posedge clk) disable iff (srst)
    ce && regRd && inStd && !pageBit |=> regRdata == 8'h00) else $error("std read while synth page");
  pump_ua_a: assert property (@(posedge clk) disable iff (srst)
    act_q.pump == 4'hB |-> pumpMicroamp == 13'h1068) else $error("pump code 11 not 4200 uA");
  ref_bypass_a: assert property (@(posedge clk) disable iff (srst)
    ce && refTick && act_q.rword == 5'h01 && !act_q.half |-> pfdTick) else $error("bypassed counter lost edge");
  ref_tick_a: assert property (@(posedge clk) disable iff (srst)
    pfdTick |-> refTick) else $error("comparison pulse without reference edge");
  range_45_a: assert property (@(posedge clk) disable iff (srst)
    !prescalerEightNine && act_q.whole == fns_pkg::INT_MIN_45 |-> divideInRange) else $error("4/5 low end refused");
  range_89_a: assert property (@(posedge clk) disable iff (srst)
    prescalerEightNine && act_q.whole == fns_pkg::INT_MAX_89 |-> divideInRange) else $error("8/9 high end refused");
  // Feedback and modulator: one ratio per feedback cycle, frozen when powered down.
  sequence fbLoad;
    ce && fbEnd && !calStart;
  endsequence
  int_ratio_a: assert property (@(posedge clk) disable iff (srst)
    fbLoad ##0 (intMode || pdLive) |=> nCnt_q == {1'b0, $past(act_q.whole)})
    else $error("integer mode ratio not whole part");
  fb_ratio_a: assert property (@(posedge clk) disable iff (srst)
    fbLoad |=> nCnt_q - {1'b0, $past(act_q.whole)} <= 17'h0_0001) else $error("feedback ratio off whole part");
  fb_tick_a: assert property (@(posedge clk) disable iff (srst)
    fbTick |-> vcoTick && ce) else $error("feedback pulse without oscillator edge");
  pd_freeze_a: assert property (@(posedge clk) disable iff (srst)
    pdLive && !calStart |=> $stable(pri_q) && $stable(aux_q)) else $error("modulator moved while powered down");
  // Clock enable low holds every flop, reset aside.
  freeze_ce_a: assert property (@(posedge clk) disable iff (srst)
    !ce |=> $stable(act_q) && $stable(refAcc_q) && $stable(nCnt_q) && $stable(regRdata) && $stable(calStart))
    else $error("state moved while clock enable low");
endmodule
`default_nettype wire

// file: testbench/fns_host_model.sv
// Behavioural address-and-strobe bus host that programs the synthesizer register map.
// Assumes the block takes strobes on the rising edge and answers reads one cycle later.
`timescale 1ns/10ps
`default_nettype none
module fns_host_model (
  input wire logic clk, // Bus clock.
  output logic [14:0] regAddr, // Register address.
  output logic [7:0] regWdata, // Write data.
  output logic regWr, // Write strobe.
  output logic regRd, // Read strobe.
  input wire logic [7:0] regRdata // Read data.
);
  // Wanted register image; addresses left out are written as zero.
  logic [7:0] cfg [logic [14:0]];
  // -------------------------------------------------------------
  // Bus cycles
  // -------------------------------------------------------------
  // The idle bus carries inverted values so stale data never looks valid.
  initial
  begin
    regAddr = 15'h7FFF;
    regWdata = 8'hFF;
    regWr = 1'b0;
    regRd = 1'b0;
  end
  // Returns one step after the accepting edge, so callers see the written state settled.
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    regAddr <= ~a;
    regWdata <= ~d;
    #1;
  endtask
  // Data is taken one step after the edge that accepted the strobe.
  task automatic rd(input logic [14:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    regAddr <= ~a;
    #1;
    d = regRdata;
  endtask
  // -------------------------------------------------------------
  // Programming sequences
  // -------------------------------------------------------------
  // Top-down order puts buffered fields in place before the apply write.
  task automatic span(input int hi, input int lo);
    for (int a = hi; a >= lo; a--)
      wr(15'(a), cfg.exists(15'(a)) ? cfg[15'(a)] : 8'h00);
  endtask
  task automatic init_seq;
    wr(fns_pkg::STD_CFG_ADDR, 8'h18);
    wr(fns_pkg::PAGE_ADDR, 8'h4C);
    span(int'(fns_pkg::MIX_LAST_ADDR), int'(fns_pkg::MIX_FIRST_ADDR));
    wr(fns_pkg::PAGE_ADDR, 8'h0C);
    span(int'(fns_pkg::SYN_LAST_ADDR), int'(fns_pkg::SYN_FIRST_ADDR));
  endtask
  task automatic update;
    span(int'(fns_pkg::M2_HI_ADDR), int'(fns_pkg::INT_LO_ADDR));
  endtask
endmodule
`default_nettype wire

// file: testbench/fns_divider_config_test.sv
// Self-checking bench of the divider configuration block.
// Assumes the host model drives the register bus and this module drives ticks.
`timescale 1ns/10ps
`default_nettype none
module fns_divider_config_test;
  logic clk, srst, ce, refTick, vcoTick, regWr, regRd, pfdTick, fbTick, calStart;
  logic intMode, modPowerDown, prescalerEightNine, divideInRange, sdoEnable, readPageSynth;
  logic [14:0] regAddr;
  logic [7:0] regWdata, regRdata, rdv;
  logic [3:0] pumpCode;
  logic [12:0] pumpMicroamp;
  logic [1:0] prescalerBias;
  int num_errors = 0;
  int checked = 0;
  int pfdCnt = 0;
  int fbCnt = 0;
  int rw[5] = '{1, 3, 0, 5, 1};
  int rc[5] = '{32, 16, 0, 48, 0};
  int rn[5] = '{8, 60, 64, 50, 7};
  int re[5] = '{8, 10, 2, 10, 7};
  int pw[8] = '{22, 23, 511, 512, 74, 75, 1023, 1024};
  fns_divider_config i_dut (.clk(clk), .srst(srst), .ce(ce), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .refTick(refTick), .vcoTick(vcoTick),
    .pfdTick(pfdTick), .fbTick(fbTick), .calStart(calStart), .pumpCode(pumpCode),
    .pumpMicroamp(pumpMicroamp), .intMode(intMode), .modPowerDown(modPowerDown),
    .prescalerBias(prescalerBias), .prescalerEightNine(prescalerEightNine),
    .divideInRange(divideInRange), .sdoEnable(sdoEnable), .readPageSynth(readPageSynth));
  fns_host_model i_host (.clk(clk), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata));
  // -------------------------------------------------------------
  // Clock, pulse counters and helpers
  // -------------------------------------------------------------
  // A 5 ns period gives the 200 MHz system clock.
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Counting on the edge sees the settled comparison pulses of the past cycle.
  always @(posedge clk)
  begin
    if (pfdTick === 1'b1) pfdCnt++;
    if (fbTick === 1'b1) fbCnt++;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Waits past the apply cycle, when dividers restart from zero.
  task automatic settle;
    repeat (2) @(posedge clk);
    pfdCnt = 0;
    fbCnt = 0;
  endtask
  task automatic pulse(input int n, input bit isRef);
    repeat (n)
    begin
      @(posedge clk);
      if (isRef) refTick <= 1'b1;
      else vcoTick <= 1'b1;
    end
    @(posedge clk);
    refTick <= 1'b0;
    vcoTick <= 1'b0;
    @(posedge clk);
  endtask
  // The limit leaves ample room over the few thousand cycles the tests need.
  initial
  begin
    #200_000;
    num_errors++;
    print_verdict;
  end
  // -------------------------------------------------------------
  // Test sequence
  // -------------------------------------------------------------
  initial
  begin
    srst = 1'b1;
    ce = 1'b1;
    refTick = 1'b0;
    vcoTick = 1'b0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    chk("pumpMicroamp", pumpMicroamp, 350);
    chk("intMode", intMode, 1);
    i_host.rd(fns_pkg::PUMP_ADDR, rdv);
    chk("pump shadow", rdv, fns_pkg::RST_PUMP);
    $display("Test reset done");
    i_host.cfg[fns_pkg::PUMP_ADDR] = 8'hB0;
    i_host.cfg[fns_pkg::RWORD_ADDR] = 8'h02;
    i_host.cfg[fns_pkg::BIAS_ADDR] = 8'h01;
    i_host.cfg[fns_pkg::INT_LO_ADDR] = 8'h1E;
    i_host.cfg[fns_pkg::M2_LO_ADDR] = 8'h02;
    i_host.cfg[fns_pkg::MIX_LAST_ADDR] = 8'h5A;
    i_host.init_seq;
    settle;
    chk("sdoEnable", sdoEnable, 1);
    chk("prescalerBias", prescalerBias, 1);
    chk("pumpCode", pumpCode, 11);
    chk("pumpMicroamp", pumpMicroamp, 4200);
    i_host.wr(fns_pkg::PAGE_ADDR, 8'h4C);
    chk("readPageSynth", readPageSynth, 0);
    i_host.rd(fns_pkg::MIX_LAST_ADDR, rdv);
    chk("mix read", rdv, 8'h5A);
    i_host.rd(fns_pkg::STD_CFG_ADDR, rdv);
    chk("std read", rdv, 8'h18);
    i_host.rd(fns_pkg::INT_LO_ADDR, rdv);
    chk("synth hidden", rdv, 8'h00);
    i_host.wr(fns_pkg::PAGE_ADDR, 8'h0C);
    chk("readPageSynth", readPageSynth, 1);
    i_host.rd(fns_pkg::STD_CFG_ADDR, rdv);
    chk("std hidden", rdv, 8'h00);
    i_host.rd(fns_pkg::MIX_LAST_ADDR, rdv);
    chk("mix hidden", rdv, 8'h00);
    $display("Test init and pages done");
    i_host.wr(fns_pkg::PUMP_ADDR, 8'h30);
    chk("pump held", pumpCode, 11);
    i_host.wr(fns_pkg::INT_LO_ADDR, 8'h1E);
    #1;
    chk("calStart", calStart, 1);
    @(posedge clk);
    #1;
    chk("pump applied", pumpCode, 3);
    chk("pumpMicroamp", pumpMicroamp, 1400);
    $display("Test buffering done");
    for (int i = 0; i < 5; i++)
    begin
      i_host.wr(fns_pkg::RWORD_ADDR, 8'(rw[i]));
      i_host.wr(fns_pkg::REFCTL_ADDR, 8'(rc[i]));
      i_host.wr(fns_pkg::INT_LO_ADDR, 8'h1E);
      settle;
      pulse(rn[i], 1'b1);
      chk("pfd count", pfdCnt, re[i]);
    end
    $display("Test reference path done");
    i_host.update;
    settle;
    pulse(301, 1'b0);
    chk("fb integer", fbCnt, 11);
    i_host.cfg[fns_pkg::F1_B3_ADDR] = 8'h01;
    i_host.update;
    settle;
    chk("intMode", intMode, 0);
    pulse(611, 1'b0);
    chk("fb fraction", fbCnt, 21);
    i_host.wr(fns_pkg::SDPD_ADDR, 8'h01);
    chk("modPowerDown", modPowerDown, 1);
    i_host.update;
    settle;
    pulse(301, 1'b0);
    chk("fb frozen", fbCnt, 11);
    i_host.wr(fns_pkg::SDPD_ADDR, 8'h00);
    $display("Test feedback done");
    for (int i = 0; i < 8; i++)
    begin
      i_host.wr(fns_pkg::PRESEL_ADDR, (i >= 4) ? 8'h20 : 8'h00);
      i_host.wr(fns_pkg::INT_HI_ADDR, 8'(pw[i] >> 8));
      i_host.wr(fns_pkg::INT_LO_ADDR, 8'(pw[i]));
      settle;
      #1;
      chk("prescalerEightNine", prescalerEightNine, (i >= 4));
      chk("divideInRange", divideInRange, (i % 4 == 1) || (i % 4 == 2));
    end
    $display("Test prescaler done");
    // A write offered while the clock enable is low must leave the register untouched.
    @(posedge clk);
    ce <= 1'b0;
    i_host.wr(fns_pkg::PUMP_ADDR, 8'h70);
    @(posedge clk);
    ce <= 1'b1;
    i_host.rd(fns_pkg::PUMP_ADDR, rdv);
    chk("write under ce low", rdv, 8'h30);
    $display("Test clock enable done");
    print_verdict;
  end
endmodule
`default_nettype wire
